// *** logic/scs_pkg.sv ***
// shared constants, types and register map of the system clock source select block
package scs_pkg;

  // ----------------------------------------------------------------
  // register bus geometry and offsets
  // ----------------------------------------------------------------
  localparam int SCS_AW = 4;
  localparam int SCS_DW = 32;
  localparam logic [SCS_AW-1:0] SCS_SYSCFG_OFS = 4'h0;
  localparam logic [SCS_AW-1:0] SCS_PLLCFG_OFS = 4'h4;
  localparam logic [SCS_AW-1:0] SCS_PRESC_OFS = 4'h8;
  localparam logic [SCS_AW-1:0] SCS_STATUS_OFS = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SCS_SEL_LSB = 0;    // system_clock_config[1:0] clock_source_select
  localparam int SCS_OSCINT_BIT = 2; // system_clock_config[2] internal oscillator
  localparam int SCS_BYPASS_BIT = 0; // pll_config[0] oscillator_bypass
  localparam int SCS_PLL_INPUT_DIVIDER_FIELD_LSB = 1;   // pll_config[4:1]
  localparam int SCS_PLL_MULTIPLIER_FIELD_LSB = 5;   // pll_config[11:5]
  localparam int SCS_PLL_OUTPUT_DIVIDER_FIELD_LSB = 12; // pll_config[18:12]
  localparam int SCS_PRESCALER_DIVIDER_FIELD_LSB = 0;  // prescaler register [9:0]
  localparam int SCS_PW = 4;
  localparam int SCS_NW = 7;
  localparam int SCS_K2W = 7;
  localparam int SCS_K1W = 10;

  // ----------------------------------------------------------------
  // modes and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCS_SRC_OFF = 2'b00,
    SCS_SRC_RSV = 2'b01,
    SCS_SRC_OSC = 2'b10,
    SCS_SRC_DIRECT = 2'b11
  } scs_mode_e;

  localparam logic [1:0] SCS_SEL_RST = 2'b11;
  localparam logic SCS_BYPASS_RST = 1'b1;
  localparam logic [SCS_K1W-1:0] SCS_PRESCALER_DIVIDER_FIELD_RST = 10'h000;
  localparam logic [15:0] SCS_PLL_STEP_RST = 16'h1000;
  localparam logic [15:0] SCS_PLL_STEP_MAX = 16'h7FFF;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sel;
    logic osc_int;
    logic bypass;
    logic [SCS_PW-1:0] pll_input_divider_field;
    logic [SCS_NW-1:0] pll_multiplier_field;
    logic [SCS_K2W-1:0] pll_output_divider_field;
    logic [SCS_K1W-1:0] prescaler_divider_field;
  } scs_cfg_s;

  typedef struct packed {
    logic [SCS_AW-1:0] addr;
    logic [SCS_DW-1:0] wdata;
    logic wr;
    logic rd;
  } scs_bus_s;

endpackage

// *** logic/scs_prescaler.sv ***
// oscillator prescaler dividing by prescaler_divider_field plus one
`timescale 1ns/1ps
module scs_prescaler #(
  parameter int K1W = 10
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic restart_in,
  input wire logic [K1W-1:0] prescaler_divider_field_in,
  // oscillator level and divided clock
  input wire logic osc_in,
  output logic div_clk_out
);
  // elaboration check: the counter and the half-period compare need 1 to 16 bits
  if (K1W < 1 || K1W > 16) begin : g_bad_k1w
    $error("scs_prescaler: K1W out of range");
  end

  logic osc_q_r;
  logic [K1W-1:0] cnt_r;
  logic hi_r;
  logic [K1W:0] half_w;
  logic [K1W-1:0] cnt_nxt;
  logic rise_w;

  // high for ceil(k1/2) oscillator periods, low for the rest
  assign rise_w = osc_in & ~osc_q_r;
  assign half_w = ({1'b0, prescaler_divider_field_in} + (K1W+1)'(2)) >> 1;
  assign cnt_nxt = (cnt_r >= prescaler_divider_field_in) ? '0 : cnt_r + K1W'(1);
  // factor one passes the oscillator level and its duty cycle untouched
  assign div_clk_out = (prescaler_divider_field_in == '0) ? osc_in : hi_r;

  // count oscillator rising edges modulo the factor
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      osc_q_r <= 1'b0;
      cnt_r <= '0;
      hi_r <= 1'b0;
    end else begin
      osc_q_r <= osc_in;
      if (restart_in) begin
        // park the count at its end so the first edge opens a full period, no short high
        cnt_r <= '1;
        hi_r <= 1'b0;
      end else if (rise_w) begin
        cnt_r <= cnt_nxt;
        hi_r <= ({1'b0, cnt_nxt} < half_w);
      end
    end
  end
endmodule

// *** logic/scs_pll.sv ***
// digital frequency locked loop giving ref times n over p times k2
`timescale 1ns/1ps
module scs_pll #(
  parameter int PW = 4,
  parameter int NW = 7,
  parameter int K2W = 7
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic enable_in,
  input wire logic [PW-1:0] pll_input_divider_field_in,
  input wire logic [NW-1:0] pll_multiplier_field_in,
  input wire logic [K2W-1:0] pll_output_divider_field_in,
  // reference and output
  input wire logic ref_in,
  output logic pll_clk_out,
  output logic locked_out
);
  import scs_pkg::*;
  localparam int WW = PW + K2W + 2;
  localparam int CW = NW + 2;
  // elaboration check: every divider field needs at least one bit
  if (PW < 1 || NW < 1 || K2W < 1) begin : g_bad_width
    $error("scs_pll: field widths must be positive");
  end

  logic ref_q_r;
  logic out_q_r;
  logic [15:0] acc_r;
  logic [15:0] step_r;
  logic [WW-1:0] win_r;
  logic [CW-1:0] cnt_r;
  logic locked_r;
  logic armed_r;
  logic [WW-1:0] win_len_w;
  logic [CW-1:0] n_w;
  logic [CW-1:0] cnt_now_w;
  logic win_end_w;
  logic out_rise_w;

  // feedback window of p times k2 reference periods should hold n output periods
  // product formed at full window width so large p times k2 does not wrap
  assign win_len_w = (WW'(pll_input_divider_field_in) + WW'(1)) * (WW'(pll_output_divider_field_in) + WW'(1));
  assign n_w = CW'({1'b0, pll_multiplier_field_in}) + CW'(1);
  // greater-or-equal so a shrunk window cannot leave the count stranded past its end
  assign win_end_w = ref_in & ~ref_q_r & (win_r >= win_len_w - WW'(1));
  assign out_rise_w = acc_r[15] & ~out_q_r;
  // a rise in the closing cycle still belongs to the window that ends there
  assign cnt_now_w = (out_rise_w && cnt_r != '1) ? cnt_r + CW'(1) : cnt_r;
  assign pll_clk_out = acc_r[15];
  assign locked_out = locked_r;

  // phase accumulator and one-step frequency trim per window, never a jump
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ref_q_r <= 1'b0;
      out_q_r <= 1'b0;
      acc_r <= '0;
      step_r <= SCS_PLL_STEP_RST;
      win_r <= '0;
      cnt_r <= '0;
      locked_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (!enable_in) begin
      ref_q_r <= ref_in;
      out_q_r <= 1'b0;
      acc_r <= '0;
      win_r <= '0;
      cnt_r <= '0;
      locked_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      ref_q_r <= ref_in;
      out_q_r <= acc_r[15];
      acc_r <= acc_r + step_r;
      if (win_end_w) begin
        win_r <= '0;
        cnt_r <= '0;
        armed_r <= 1'b1;
        // the window begun at enable is partial, so it neither trims nor locks
        locked_r <= armed_r && (cnt_now_w == n_w);
        if (armed_r && cnt_now_w < n_w && step_r < SCS_PLL_STEP_MAX) begin
          step_r <= step_r + 16'h0001;
        end else if (armed_r && cnt_now_w > n_w && step_r > 16'h0001) begin
          step_r <= step_r - 16'h0001;
        end
      end else begin
        if (ref_in & ~ref_q_r) win_r <= win_r + WW'(1);
        cnt_r <= cnt_now_w;
      end
    end
  end
endmodule

// *** logic/scs_clock_select.sv ***
// system clock source select: direct drive, prescaler and pll with glitch-free switching
//
// Functional notes
// - select value 11 makes the system clock follow the direct clock input at its frequency.
// - in direct drive the output copies the input level so its duty cycle is kept.
// - select 10 with bypass 1 divides the oscillator by the prescaler field plus one.
// - the prescaler oscillator is either the crystal input or the internal oscillator.
// - a prescaler factor of one passes the oscillator level and its duty cycle unchanged.
// - the largest prescaler field gives divide by 1024, the slowest clock.
// - select 10 with bypass 0 enables the pll and takes its output as system clock.
// - the pll output runs at the reference times n over p times k2, each field plus one.
// - the pll reference is either the crystal input or the internal oscillator.
// - the pll trims its frequency one small step at a time, never abruptly.
// - bypass from the crystal with factor one behaves like direct drive.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module scs_clock_select (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire scs_pkg::scs_bus_s bus_in,
  output logic [scs_pkg::SCS_DW-1:0] rdata_out,
  // clock sources
  input wire logic direct_clock_input_in,
  input wire logic crystal_input_pin_in,
  input wire logic internal_osc_in,
  // generated clock and status
  output logic sys_clock_out,
  output logic pll_lock_out
);
  import scs_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  scs_cfg_s cfg_sw_r;
  scs_cfg_s cfg_act_r;
  logic pending_r;
  logic clk_r;
  logic lock_r;
  logic [SCS_DW-1:0] rdata_r;
  scs_mode_e mode_w;
  logic sel_syscfg_w;
  logic sel_pllcfg_w;
  logic sel_presc_w;
  logic sel_status_w;
  logic apply_w;
  logic osc_w;
  logic presc_clk_w;
  logic pll_clk_w;
  logic pll_locked_w;
  logic pll_en_w;
  logic clk_nxt;
  logic [SCS_DW-1:0] rd_syscfg_w;
  logic [SCS_DW-1:0] rd_pllcfg_w;
  logic [SCS_DW-1:0] rd_presc_w;
  logic [SCS_DW-1:0] rd_status_w;
  logic [SCS_DW-1:0] rdata_nxt;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign sel_syscfg_w = (bus_in.addr == SCS_SYSCFG_OFS);
  assign sel_pllcfg_w = (bus_in.addr == SCS_PLLCFG_OFS);
  assign sel_presc_w = (bus_in.addr == SCS_PRESC_OFS);
  assign sel_status_w = (bus_in.addr == SCS_STATUS_OFS);

  // ----------------------------------------------------------------
  // software configuration registers
  // ----------------------------------------------------------------
  // writes land in a shadow copy; the clock path only sees the applied copy
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_sw_r <= '{sel: SCS_SEL_RST, osc_int: 1'b0, bypass: SCS_BYPASS_RST,
                    pll_input_divider_field: '0, pll_multiplier_field: '0, pll_output_divider_field: '0, prescaler_divider_field: SCS_PRESCALER_DIVIDER_FIELD_RST};
    end else if (bus_in.wr) begin
      if (sel_syscfg_w) begin
        cfg_sw_r.sel <= bus_in.wdata[SCS_SEL_LSB +: 2];
        cfg_sw_r.osc_int <= bus_in.wdata[SCS_OSCINT_BIT];
      end
      if (sel_pllcfg_w) begin
        cfg_sw_r.bypass <= bus_in.wdata[SCS_BYPASS_BIT];
        cfg_sw_r.pll_input_divider_field <= bus_in.wdata[SCS_PLL_INPUT_DIVIDER_FIELD_LSB +: SCS_PW];
        cfg_sw_r.pll_multiplier_field <= bus_in.wdata[SCS_PLL_MULTIPLIER_FIELD_LSB +: SCS_NW];
        cfg_sw_r.pll_output_divider_field <= bus_in.wdata[SCS_PLL_OUTPUT_DIVIDER_FIELD_LSB +: SCS_K2W];
      end
      if (sel_presc_w) begin
        cfg_sw_r.prescaler_divider_field <= bus_in.wdata[SCS_PRESCALER_DIVIDER_FIELD_LSB +: SCS_K1W];
      end
    end
  end

  // ----------------------------------------------------------------
  // apply at a clock boundary
  // ----------------------------------------------------------------
  // a new setting waits for a low phase, then the output is held low for
  // one more cycle, so neither phase around a switch is shorter than a cycle
  assign apply_w = pending_r & ~clk_r;

  // pending flag: a write in the apply cycle wins and stays pending
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pending_r <= 1'b0;
    end else if (bus_in.wr && (sel_syscfg_w || sel_pllcfg_w || sel_presc_w)) begin
      pending_r <= 1'b1;
    end else if (apply_w) begin
      pending_r <= 1'b0;
    end
  end

  // applied configuration
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_act_r <= '{sel: SCS_SEL_RST, osc_int: 1'b0, bypass: SCS_BYPASS_RST,
                     pll_input_divider_field: '0, pll_multiplier_field: '0, pll_output_divider_field: '0, prescaler_divider_field: SCS_PRESCALER_DIVIDER_FIELD_RST};
    end else if (apply_w) begin
      cfg_act_r <= cfg_sw_r;
    end
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  assign mode_w = scs_mode_e'(cfg_act_r.sel);
  // one oscillator feeds both prescaler and pll reference
  assign osc_w = cfg_act_r.osc_int ? internal_osc_in : crystal_input_pin_in;
  // pll restarts at each apply so a half-changed setting never trims the step
  assign pll_en_w = (mode_w == SCS_SRC_OSC) && !cfg_act_r.bypass && !apply_w;

  // prescaler path, restarted at each apply so it starts in phase
  scs_prescaler #(
    .K1W(SCS_K1W)
  ) u_presc (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .restart_in(apply_w),
    .prescaler_divider_field_in(cfg_act_r.prescaler_divider_field),
    .osc_in(osc_w),
    .div_clk_out(presc_clk_w)
  );

  // pll path
  scs_pll #(
    .PW(SCS_PW),
    .NW(SCS_NW),
    .K2W(SCS_K2W)
  ) u_pll (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(pll_en_w),
    .pll_input_divider_field_in(cfg_act_r.pll_input_divider_field),
    .pll_multiplier_field_in(cfg_act_r.pll_multiplier_field),
    .pll_output_divider_field_in(cfg_act_r.pll_output_divider_field),
    .ref_in(osc_w),
    .pll_clk_out(pll_clk_w),
    .locked_out(pll_locked_w)
  );

  // ----------------------------------------------------------------
  // output clock mux
  // ----------------------------------------------------------------
  // reserved select codes stop the clock low rather than guess a source
  always_comb begin
    clk_nxt = 1'b0;
    if (!apply_w) begin
      case (mode_w)
        SCS_SRC_DIRECT: begin
          clk_nxt = direct_clock_input_in;
        end
        SCS_SRC_OSC: begin
          if (cfg_act_r.bypass) begin
            clk_nxt = presc_clk_w;
          end else begin
            clk_nxt = pll_clk_w;
          end
        end
        SCS_SRC_OFF: begin
          clk_nxt = 1'b0;
        end
        default: begin
          clk_nxt = 1'b0;
        end
      endcase
    end
  end

  // output flops; the copy costs one cycle of delay in every mode
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clk_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      clk_r <= clk_nxt;
      lock_r <= pll_locked_w;
    end
  end

  assign sys_clock_out = clk_r;
  assign pll_lock_out = lock_r;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  assign rd_syscfg_w = SCS_DW'({cfg_sw_r.osc_int, cfg_sw_r.sel});
  assign rd_pllcfg_w = SCS_DW'({cfg_sw_r.pll_output_divider_field, cfg_sw_r.pll_multiplier_field, cfg_sw_r.pll_input_divider_field, cfg_sw_r.bypass});
  assign rd_presc_w = SCS_DW'(cfg_sw_r.prescaler_divider_field);
  // status: applied select, applied bypass, pending, lock, clock level
  assign rd_status_w = SCS_DW'({clk_r, lock_r, pending_r, cfg_act_r.bypass, cfg_act_r.sel});
  // unmapped offsets read as zero
  assign rdata_nxt = sel_syscfg_w ? rd_syscfg_w :
                     sel_pllcfg_w ? rd_pllcfg_w :
                     sel_presc_w ? rd_presc_w :
                     sel_status_w ? rd_status_w : '0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= '0;
    end else if (bus_in.rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_out = rdata_r;
endmodule

// *** verif/scs_clock_select_properties.sv ***
// assertions on the ports of the clock select block
`timescale 1ns/1ps
module scs_clock_select_properties (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire scs_pkg::scs_bus_s bus_in,
  input wire logic [scs_pkg::SCS_DW-1:0] rdata_out,
  // sources and outputs
  input wire logic direct_clock_input_in,
  input wire logic crystal_input_pin_in,
  input wire logic internal_osc_in,
  input wire logic sys_clock_out,
  input wire logic pll_lock_out
);
  import scs_pkg::*;
  // ----------------
  // helper model
  // ----------------
  localparam scs_cfg_s RST = '{SCS_SEL_RST, 1'b0, SCS_BYPASS_RST, '0, '0, '0, SCS_PRESCALER_DIVIDER_FIELD_RST};
  scs_cfg_s sh_r, app_r;
  logic pend_r, out_d_r, osc_d_r;
  logic [1:0] settle_r, seen_r;
  logic [11:0] cnt_r, per_r, prev_r;
  wire [31:0] wd = bus_in.wdata;
  wire hit_sys = bus_in.wr && bus_in.addr == SCS_SYSCFG_OFS;
  wire hit_pll = bus_in.wr && bus_in.addr == SCS_PLLCFG_OFS;
  wire hit_k1 = bus_in.wr && bus_in.addr == SCS_PRESC_OFS;
  wire settled = !pend_r && settle_r == 2'd3;
  wire osc = app_r.osc_int ? internal_osc_in : crystal_input_pin_in;
  wire rose = sys_clock_out && !out_d_r;
  wire presc = app_r.sel == SCS_SRC_OSC && app_r.bypass;
  wire pll = app_r.sel == SCS_SRC_OSC && !app_r.bypass;
  // apply happens at the first low output; settle gives margin for the forced low cycle
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sh_r <= RST;
      app_r <= RST;
      {pend_r, out_d_r, osc_d_r, settle_r, seen_r} <= '0;
      {cnt_r, per_r, prev_r} <= '0;
    end else begin
      if (hit_sys) {sh_r.osc_int, sh_r.sel} <= wd[2:0];
      if (hit_pll) {sh_r.pll_output_divider_field, sh_r.pll_multiplier_field, sh_r.pll_input_divider_field, sh_r.bypass} <= wd[18:0];
      if (hit_k1) sh_r.prescaler_divider_field <= wd[9:0];
      if (hit_sys || hit_pll || hit_k1) begin
        pend_r <= 1'b1;
        settle_r <= 2'd0;
      end else if (pend_r && !sys_clock_out) begin
        pend_r <= 1'b0;
        app_r <= sh_r;
        settle_r <= 2'd0;
      end else if (settle_r != 2'd3) settle_r <= settle_r + 2'd1;
      out_d_r <= sys_clock_out;
      osc_d_r <= osc;
      cnt_r <= rose ? 12'd0 : cnt_r + {11'd0, osc && !osc_d_r};
      per_r <= rose ? 12'd1 : per_r + 12'd1;
      if (rose) prev_r <= per_r;
      if (!settled) seen_r <= 2'd0;
      else if (rose && seen_r != 2'd2) seen_r <= seen_r + 2'd1;
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_RDATA_IDLE: assert property (
    !$past(bus_in.rd) |-> rdata_out == '0) else $error("read data outside a read answer");
  AST_DIRECT_COPY: assert property (
    settled && app_r.sel == SCS_SRC_DIRECT |-> sys_clock_out == $past(direct_clock_input_in))
    else $error("direct drive does not copy the input");
  AST_OSC_COPY: assert property (
    settled && presc && app_r.prescaler_divider_field == '0 |-> sys_clock_out == $past(osc))
    else $error("factor one does not copy the oscillator");
  AST_APPLY_LOW: assert property (
    pend_r && !sys_clock_out && !bus_in.wr |-> !sys_clock_out[*2])
    else $error("output not held low around a change");
  AST_PRESC_PERIOD: assert property (
    rose && seen_r != 2'd0 && settled && presc && app_r.prescaler_divider_field != '0
    |-> cnt_r == {2'b00, app_r.prescaler_divider_field} + 12'd1) else $error("prescaler period wrong");
  AST_PLL_RUNS: assert property (
    settled && pll && seen_r != 2'd0 |-> per_r < 12'd64) else $error("pll output stopped");
  AST_PLL_SMOOTH: assert property (
    rose && settled && pll && seen_r == 2'd2
    |-> per_r <= prev_r + 12'd1 && prev_r <= per_r + 12'd1)
    else $error("pll period jumped");
  AST_LOCK_OFF: assert property (
    settled && !pll |-> !pll_lock_out) else $error("lock shown while pll is off");
  AST_OFF_LOW: assert property (
    settled && !app_r.sel[1] |-> !sys_clock_out) else $error("stopped clock not low");
endmodule

// *** verif/scs_osc_model.sv ***
// clock source levels: direct input, crystal and internal oscillator
`timescale 1ns/1ps
module scs_osc_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // high and low lengths in cycles, a byte per source: direct, crystal, internal
  input wire logic [23:0] hi_in,
  input wire logic [23:0] lo_in,
  // source levels
  output logic [2:0] src_out
);
  logic [7:0] cnt_r [3];
  // free toggling; uneven high and low lengths expose duty-cycle reshaping
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_out <= '0;
      cnt_r <= '{default: '0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cnt_r[i] + 8'd1 >= (src_out[i] ? hi_in[8*i+:8] : lo_in[8*i+:8])) begin
          src_out[i] <= !src_out[i];
          cnt_r[i] <= '0;
        end else cnt_r[i] <= cnt_r[i] + 8'd1;
      end
    end
  end
endmodule

// *** verif/test_scs_clock_select.sv ***
// self-checking bench for the clock select block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_scs_clock_select;
  import scs_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  scs_bus_s bus = '0;
  logic [SCS_DW-1:0] rdata;
  logic [2:0] src;
  logic sclk, lock, rd_d = 1'b0, win = 1'b0, win_d = 1'b0, sclk_d = 1'b0;
  logic [23:0] hi = 24'h04_0203, lo = 24'h02_0202;
  logic [15:0] lfsr = 16'h0045;
  logic [31:0] exp_q[$], mask_q[$], e, m;
  logic [9:0] k1r;
  string name_q[$], nm;
  int fails = 0, n_compared = 0, rises = 0;
  scs_clock_select uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .bus_in(bus),
    .rdata_out(rdata), .direct_clock_input_in(src[0]), .crystal_input_pin_in(src[1]),
    .internal_osc_in(src[2]), .sys_clock_out(sclk), .pll_lock_out(lock));
  scs_osc_model osc (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .hi_in(hi), .lo_in(lo),
    .src_out(src));
  always #10 sys_clk_in = ~sys_clk_in;
  // ----------------
  // drivers
  // ----------------
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic put(input logic [3:0] a, input logic [31:0] d, input logic r);
    @(posedge sys_clk_in);
    bus <= '{a, d, !r, r};
    @(posedge sys_clk_in);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ev, input logic [31:0] mv,
      input string n);
    exp_q.push_back(ev);
    mask_q.push_back(mv);
    name_q.push_back(n);
    put(a, '0, 1'b1);
  endtask
  task automatic measure(input int w, input int ev);
    exp_q.push_back(32'(ev));
    mask_q.push_back('1);
    name_q.push_back("rises");
    @(posedge sys_clk_in);
    win <= 1'b1;
    repeat (w) @(posedge sys_clk_in);
    win <= 1'b0;
  endtask
  // skips the partial period that follows a restart
  task automatic wait_rises(input int n);
    int k = 0;
    repeat (20000) begin
      @(posedge sys_clk_in);
      if (sclk && !sclk_d) k++;
      if (k >= n) break;
    end
  endtask
  task automatic run(input logic [1:0] s, input logic oi, input logic b, input logic [3:0] p,
      input logic [6:0] n, input logic [6:0] k2, input logic [9:0] k1, input int w, input int ev);
    put(SCS_PRESC_OFS, {22'h0, k1}, 1'b0);
    put(SCS_PLLCFG_OFS, {13'h0, k2, n, p, b}, 1'b0);
    put(SCS_SYSCFG_OFS, {29'h0, oi, s}, 1'b0);
    if (ev > 0) wait_rises(2);
    measure(w, ev);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------
  // monitor and sequence
  // ----------------
  // each read answer or window end takes the oldest note
  always @(posedge sys_clk_in) begin
    if (rd_d || (win_d && !win)) begin
      nm = name_q.pop_front();
      e = exp_q.pop_front();
      m = mask_q.pop_front();
      `CHK(nm, e, (rd_d ? rdata : 32'(rises)) & m)
    end
    if (win) rises <= (win_d ? rises : 0) + int'(sclk && !sclk_d);
    rd_d <= bus.rd;
    sclk_d <= sclk;
    win_d <= win;
  end
  initial begin
    repeat (80000) @(posedge sys_clk_in);
    fails++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rd(SCS_SYSCFG_OFS, 32'h0000_0003, '1, "sys_cfg");
    rd(SCS_PLLCFG_OFS, 32'h0000_0001, '1, "pll_cfg");
    rd(SCS_PRESC_OFS, 32'h0000_0000, '1, "presc");
    rd(SCS_STATUS_OFS, 32'h0000_0007, 32'h0000_000F, "status");
    lfsr = nxt(lfsr);
    put(4'h6, {16'h0, lfsr}, 1'b0);
    rd(4'h6, '0, '1, "unmapped");
    put(SCS_PRESC_OFS, 32'hFFFF_FC05, 1'b0);
    rd(SCS_PRESC_OFS, 32'h0000_0005, '1, "presc_bits");
    run(2'b11, '0, '1, '0, '0, '0, '0, 500, 100);
    run(2'b10, '0, '1, '0, '0, '0, '0, 400, 100);
    run(2'b10, '1, '1, '0, '0, '0, '0, 600, 100);
    run(2'b10, '0, '1, '0, '0, '0, 10'd2, 600, 50);
    lfsr = nxt(lfsr);
    k1r = {7'h0, lfsr[2:0] | 3'd1};
    run(2'b10, '1, '1, '0, '0, '0, k1r, 60 * (int'(k1r) + 1), 10);
    run(2'b10, '0, '1, '0, '0, '0, 10'h3FF, 8192, 2);
    run(2'b01, '0, '1, '0, '0, '0, '0, 200, 0);
    hi <= 24'h10_0803;
    lo <= 24'h10_0802;
    run(2'b10, '1, '0, 4'd1, 7'd3, 7'd0, '0, 640, 40);
    rd(SCS_STATUS_OFS, 32'h0000_0012, 32'h0000_001F, "status");
    rd(SCS_PLLCFG_OFS, 32'h0000_0062, '1, "pll_cfg");
    run(2'b10, '0, '0, 4'd0, 7'd2, 7'd2, '0, 640, 40);
    rd(SCS_STATUS_OFS, 32'h0000_0012, 32'h0000_001F, "status");
    run(2'b11, '0, '1, '0, '0, '0, '0, 500, 100);
    // let the monitor take the last window's note before the verdict
    repeat (2) @(posedge sys_clk_in);
    close_out();
  end
endmodule
bind scs_clock_select scs_clock_select_properties chk (.sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .direct_clock_input_in(direct_clock_input_in), .crystal_input_pin_in(crystal_input_pin_in),
  .internal_osc_in(internal_osc_in), .sys_clock_out(sys_clock_out), .pll_lock_out(pll_lock_out));
